// [bench/sxf_spi_master.sv]
// Purpose: local SPI master model on the pins of the bank
// Assumes: mode 0, MSB first, pins change on falling i_clk
// Notes:   half period of 5 clocks keeps clear of the 4 clock minimum

`timescale 1ns/1ps

module sxf_spi_master #(
    parameter int HALF = 5
) (
    input  wire logic i_clk,
    input  wire logic i_miso,
    output logic      o_sck,
    output logic      o_mosi,
    output logic      o_ss_n,
    output logic      o_ssc_n
);
    // =====================================================================
    // idle pins: both selects high, clock low
    initial begin
        o_sck   = 1'b0;
        o_mosi  = 1'b0;
        o_ss_n  = 1'b1;
        o_ssc_n = 1'b1;
    end

    // one frame of n bits; miso taken at each rise, where it is settled
    task automatic xfer(input logic ctl, input int n,
                        input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        @(negedge i_clk);
        if (ctl) begin
            o_ssc_n = 1'b0;
        end else begin
            o_ss_n = 1'b0;
        end
        for (int i = 0; i < n; i++) begin
            o_mosi = tx[n-1-i];
            repeat (HALF) @(negedge i_clk);
            o_sck = 1'b1;
            rx    = {rx[62:0], i_miso};
            repeat (HALF) @(negedge i_clk);
            o_sck = 1'b0;
        end
        o_mosi = ~o_mosi;   // no stale bit left on the line
        repeat (HALF) @(negedge i_clk);
        o_ssc_n = 1'b1;
        o_ss_n  = 1'b1;
        repeat (6) @(negedge i_clk);   // select gap above 4 clocks
    endtask
endmodule

// [bench/tb_sxf_regs.sv]
// Purpose: self-checking bench of the fault and bit count bank
// Assumes: remote bits arrive one per data SCK rise
// Notes:   i_ce drops once in a freeze test; the link stalls on overflow

`timescale 1ns/1ps

module tb_sxf_regs
    import sxf_pkg::*;
;
    localparam logic [63:0] PAT      = 64'hC3A5_96F0_1E2D_4B78;
    localparam int          LIMIT    = 20000;
    localparam logic [7:0]  VALS [4] = '{8'h5A, 8'hA5, 8'hFF, 8'h00};

    logic        clk, srst, ce, sck, mosi, ss_n, ssc_n, miso, miso_oe;
    logic        tx_v, tx_b, tx_rdy, rx_v, rx_b, flt_ev, rx_feed, sck_p;
    logic [5:0]  rise_n;
    logic [1:0]  dly;
    logic [63:0] r;
    int          num_errors, n_tests, cyc;
    logic        tx_q[$];

    // =====================================================================
    // clock and instances
    initial clk = 1'b0;
    always #5 clk = ~clk;

    sxf_regs sxf_regs_i (
        .i_clk           (clk),
        .i_srst          (srst),
        .i_ce            (ce),
        .i_sck           (sck),
        .i_mosi          (mosi),
        .i_ss_n          (ss_n),
        .i_ssc_n         (ssc_n),
        .o_miso          (miso),
        .o_miso_oe       (miso_oe),
        .o_link_tx_valid (tx_v),
        .o_link_tx_bit   (tx_b),
        .i_link_tx_ready (tx_rdy),
        .i_link_rx_valid (rx_v),
        .i_link_rx_bit   (rx_b),
        .o_fault_event   (flt_ev)
    );

    sxf_spi_master sxf_spi_master_i (
        .i_clk   (clk),
        .i_miso  (miso),
        .o_sck   (sck),
        .o_mosi  (mosi),
        .o_ss_n  (ss_n),
        .o_ssc_n (ssc_n)
    );

    // =====================================================================
    // remote bits: pulse 3 clocks after each data rise, so it is
    // pending before the matching fall gets through the synchroniser
    always @(posedge clk) begin
        sck_p <= sck;
        if (ss_n) begin
            rise_n <= 6'h00;
        end else if (sck && !sck_p) begin
            rise_n <= rise_n + 6'h01;
        end
        if (!ss_n && sck && !sck_p) begin
            dly <= 2'h3;
        end else if (dly != 2'h0) begin
            dly <= dly - 2'h1;
        end
    end

    always @(negedge clk) begin
        rx_v = rx_feed && (dly == 2'h1);
        rx_b = PAT[rise_n];
    end

    // link side collects every bit it accepts
    always @(posedge clk) begin
        if (tx_v === 1'b1 && tx_rdy) begin
            tx_q.push_back(tx_b);
        end
    end

    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            give_verdict();
        end
    end

    // =====================================================================
    // tasks
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        logic [63:0] q;
        sxf_spi_master_i.xfer(1'b1, 16, {48'h0, a, 1'b0, d}, q);
    endtask

    task automatic rd_chk(input string nm, input logic [6:0] a,
                          input logic [7:0] e);
        logic [63:0] q;
        sxf_spi_master_i.xfer(1'b1, 16, {48'h0, a, 1'b1, 8'h00}, q);
        chk(nm, e, q[7:0]);
    endtask

    // bit taken at fall k is seen at rise k+nl+1
    task automatic data_run(input int nl, input int n);
        logic [63:0] q;
        tx_q.delete();
        sxf_spi_master_i.xfer(1'b0, n, ~PAT, q);
        for (int j = nl + 2; j <= n; j++) begin
            chk("miso delay", PAT[j-nl-1], q[n-j]);
        end
        chk("link count", n, tx_q.size());
        // logical not keeps the expected bit one bit wide
        foreach (tx_q[i]) begin
            chk("link bit", !PAT[n-1-i], tx_q[i]);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // =====================================================================
    // main sequence
    initial begin
        num_errors = 0;
        n_tests    = 0;
        cyc        = 0;
        srst       = 1'b1;
        ce         = 1'b1;
        tx_rdy     = 1'b1;
        rx_feed    = 1'b1;
        rx_v       = 1'b0;
        rx_b       = 1'b0;
        sck_p      = 1'b0;
        rise_n     = 6'h00;
        dly        = 2'h0;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        chk("miso oe", 1'b0, miso_oe);
        chk("fault event", 1'b0, flt_ev);
        rd_chk("event", SXF_OFF_EVENT, 8'h00);
        rd_chk("fault", SXF_OFF_FAULT, 8'h00);
        rd_chk("bit count", SXF_OFF_WLEN, 8'h08);
        rd_chk("readback", SXF_OFF_READBACK_TEST, 8'h00);
        rd_chk("unmapped", 7'h10, 8'h00);
        foreach (VALS[i]) begin
            reg_wr(SXF_OFF_READBACK_TEST, VALS[i]);
            rd_chk("readback", SXF_OFF_READBACK_TEST, VALS[i]);
        end
        // frozen bank must ignore a whole write frame
        ce = 1'b0;
        reg_wr(SXF_OFF_READBACK_TEST, 8'h77);
        ce = 1'b1;
        rd_chk("frozen readback", SXF_OFF_READBACK_TEST, 8'h00);
        // an unmapped write must not alias onto the test register
        reg_wr(7'h10, 8'h33);
        rd_chk("readback", SXF_OFF_READBACK_TEST, 8'h00);
        // both ends of the legal bit count range
        reg_wr(SXF_OFF_WLEN, 8'h20);
        rd_chk("bit count", SXF_OFF_WLEN, 8'h20);
        data_run(32, 40);
        reg_wr(SXF_OFF_WLEN, 8'h08);
        data_run(8, 40);
        rd_chk("fault", SXF_OFF_FAULT, 8'h00);
        // link stalls: buffer fills and later bits are lost
        tx_rdy = 1'b0;
        sxf_spi_master_i.xfer(1'b0, 14, ~PAT, r);
        chk("fault event", 1'b1, flt_ev);
        rd_chk("fault", SXF_OFF_FAULT, 8'h08);
        rd_chk("event", SXF_OFF_EVENT, 8'h04);
        tx_rdy = 1'b1;
        reg_wr(SXF_OFF_FAULT, 8'h00);
        reg_wr(SXF_OFF_EVENT, 8'hFF);
        rd_chk("fault", SXF_OFF_FAULT, 8'h08);
        reg_wr(SXF_OFF_EVENT, 8'h00);
        rd_chk("fault", SXF_OFF_FAULT, 8'h00);
        chk("fault event", 1'b0, flt_ev);
        // remote bits withheld: each fall finds nothing pending
        rx_feed = 1'b0;
        sxf_spi_master_i.xfer(1'b0, 3, ~PAT, r);
        rd_chk("fault", SXF_OFF_FAULT, 8'h10);
        rd_chk("event", SXF_OFF_EVENT, 8'h04);
        reg_wr(SXF_OFF_EVENT, 8'h00);
        rd_chk("event", SXF_OFF_EVENT, 8'h00);
        give_verdict();
    end
endmodule

// [common/sxf_pkg.sv]
// Purpose: shared constants and types of the fault and word length bank
// Assumes: registers are reached over the control serial interface
// Notes:   fault flags live in one 2-bit vector, mapped to register bits

package sxf_pkg;
    // =====================================================================
    // register offsets (7-bit control address)
    localparam logic [6:0] SXF_OFF_EVENT   = 7'h02;
    localparam logic [6:0] SXF_OFF_FAULT   = 7'h04;
    localparam logic [6:0] SXF_OFF_WLEN    = 7'h05;
    localparam logic [6:0] SXF_OFF_READBACK_TEST = 7'h06;

    // =====================================================================
    // field positions
    localparam int SXF_EV_FAULT_BIT  = 2;
    localparam int SXF_FLT_TXOVF_BIT = 3;
    localparam int SXF_FLT_RXUNF_BIT = 4;
    localparam int SXF_FLT_TX        = 0;   // index inside fault vector
    localparam int SXF_FLT_RX        = 1;

    // =====================================================================
    // reset values and limits
    localparam logic [7:0] SXF_WLEN_RST    = 8'h08;
    localparam logic [7:0] SXF_READBACK_TEST_RST = 8'h00;
    localparam logic [7:0] SXF_WLEN_MIN    = 8'h08;
    localparam logic [7:0] SXF_WLEN_MAX    = 8'h20;
    localparam logic [3:0] SXF_PIN_RST     = 4'hC;  // both selects idle

    // =====================================================================
    // sizes
    localparam int SXF_FIFO_W     = 1;
    localparam int SXF_FIFO_DEPTH = 8;
    localparam int SXF_HIST_W     = 32;
    localparam logic [2:0] SXF_BYTE_LAST = 3'h7;

    // control transfer phases
    typedef enum logic [1:0] {
        SXF_ST_ADDR,
        SXF_ST_DATA,
        SXF_ST_SKIP
    } sxf_ctl_st_t;
endpackage

// [common/sxf_stream_if.sv]
// Purpose: valid/ready stream between the bank and its transmit FIFO
// Assumes: one clock, both ends inside the same block
// Notes:   in_* fills the FIFO, out_* drains it

`timescale 1ns/1ps

interface sxf_stream_if #(parameter int W = 1);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport src  (output in_valid, in_data, out_ready,
                  input  in_ready, out_valid, out_data);
    modport fifo (input  in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
endinterface

// [rtl/sxf_fifo.sv]
// Purpose: small FIFO with a registered output stage
// Assumes: single clock, synchronous reset, clock enable freezes all
// Notes:   in_ready drops only when the storage array is full

`timescale 1ns/1ps

module sxf_fifo #(
    parameter int W     = 1,
    parameter int DEPTH = 8
) (
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_ce,
    sxf_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          ov_q, ov_d;
    logic [W-1:0]  od_q, od_d;
    logic          push, pop;

    // =====================================================================
    // handshakes
    assign s.in_ready  = (cnt_q != FULL_CNT);
    assign s.out_valid = ov_q;
    assign s.out_data  = od_q;
    assign push = s.in_valid && s.in_ready;
    // refill the output register when it is empty or being taken
    assign pop  = (cnt_q != '0) && (!ov_q || s.out_ready);

    // next pointers, count and output stage
    always_comb begin
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d  = cnt_q;
        ov_d   = ov_q;
        od_d   = od_q;
        if (push) begin
            wptr_d = wptr_q + 1'b1;
        end
        if (pop) begin
            rptr_d = rptr_q + 1'b1;
            od_d   = mem[rptr_q];
            ov_d   = 1'b1;
        end else if (s.out_ready) begin
            ov_d = 1'b0;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
            ov_q   <= 1'b0;
            od_q   <= '0;
        end else if (i_ce) begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q  <= cnt_d;
            ov_q   <= ov_d;
            od_q   <= od_d;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge i_clk) begin
        if (i_ce && push) begin
            mem[wptr_q] <= s.in_data;
        end
    end
endmodule

// [rtl/sxf_regs.sv]
// Purpose: fault flags, transfer bit count and readback test register
// Assumes: local master uses SPI mode 0 on both selects, SCK << i_clk
// Notes:   control frame is one address byte {addr[6:0], rd} then data

`timescale 1ns/1ps

// Operation
// - transmit buffer overflow from fast SCK sets transmit fault flag
// - receive buffer unable to keep up sets receive fault flag
// - remote read data appears on MISO delayed by bit count SCKs clamped to 8..32
// - readback test register returns exactly what was written
// - any fault sets summary bit; clearing summary clears all faults
// - fault flags are never cleared by writing them directly
module sxf_regs
    import sxf_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_ce,
    input  wire logic i_sck,
    input  wire logic i_mosi,
    input  wire logic i_ss_n,
    input  wire logic i_ssc_n,
    output logic      o_miso,
    output logic      o_miso_oe,
    output logic      o_link_tx_valid,
    output logic      o_link_tx_bit,
    input  wire logic i_link_tx_ready,
    input  wire logic i_link_rx_valid,
    input  wire logic i_link_rx_bit,
    output logic      o_fault_event
);
    // =====================================================================
    // pin synchronisers: {ssc_n, ss_n, mosi, sck}
    logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pin_s1_q <= SXF_PIN_RST;
            pin_s2_q <= SXF_PIN_RST;
            pin_s3_q <= SXF_PIN_RST;
        end else if (i_ce) begin
            pin_s1_q <= {i_ssc_n, i_ss_n, i_mosi, i_sck};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    logic sck_rise, sck_fall, csel, dsel, mosi;
    assign sck_rise = pin_s2_q[0] && !pin_s3_q[0];
    assign sck_fall = !pin_s2_q[0] && pin_s3_q[0];
    assign mosi     = pin_s2_q[1];
    assign dsel     = !pin_s2_q[2];
    assign csel     = !pin_s2_q[3];

    // =====================================================================
    // transmit FIFO toward the link
    sxf_stream_if #(.W(SXF_FIFO_W)) tx_s ();

    sxf_fifo #(
        .W     (SXF_FIFO_W),
        .DEPTH (SXF_FIFO_DEPTH)
    ) u_tx_fifo (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_ce   (i_ce),
        .s      (tx_s.fifo)
    );

    // every sampled SCK rise of a data frame is one serial event
    assign tx_s.in_valid  = sck_rise && dsel;
    assign tx_s.in_data   = mosi;
    assign tx_s.out_ready = i_link_tx_ready;
    assign o_link_tx_valid = tx_s.out_valid;
    assign o_link_tx_bit   = tx_s.out_data;

    // =====================================================================
    // state
    sxf_ctl_st_t st_q, st_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [7:0]  csh_q, csh_d;        // control receive shifter
    logic [7:0]  ctx_q, ctx_d;        // control read shifter
    logic [6:0]  addr_q, addr_d;
    logic        rd_q, rd_d;
    logic [7:0]  wlen_q, wlen_d;
    logic [7:0]  scr_q, scr_d;
    logic [1:0]  fault_q, fault_d;
    logic        ev_q, ev_d;
    logic        rxp_q, rxp_d;        // one remote bit waiting
    logic        rxb_q, rxb_d;
    logic [SXF_HIST_W-1:0] hist_q, hist_d;
    logic        miso_q, miso_d;
    logic        oe_q, oe_d;

    logic [7:0]  byte_in, rdata;
    logic        wr_en, ev_clr, tx_ovf, rx_unf, rx_avail, rx_now;
    logic [4:0]  tap_idx;
    logic [7:0]  tap;

    assign byte_in  = {csh_q[6:0], mosi};
    assign rx_avail = rxp_q || i_link_rx_valid;
    assign rx_now   = i_link_rx_valid ? i_link_rx_bit : rxb_q;
    // out-of-range counts are clamped so the tap never leaves the line
    assign tap = (wlen_q < SXF_WLEN_MIN) ? SXF_WLEN_MIN :
                 (wlen_q > SXF_WLEN_MAX) ? SXF_WLEN_MAX : wlen_q;
    assign tap_idx = 5'(tap - 8'h01);

    // fault causes: push into a full FIFO, or SCK outrunning the link
    assign tx_ovf = tx_s.in_valid && !tx_s.in_ready;
    assign rx_unf = sck_fall && dsel && !csel && !rx_avail;

    // read mux; registers outside this bank read as zero here
    always_comb begin
        rdata = 8'h00;
        case (addr_d)
            SXF_OFF_EVENT: rdata[SXF_EV_FAULT_BIT] = ev_q;
            SXF_OFF_FAULT: begin
                rdata[SXF_FLT_TXOVF_BIT] = fault_q[SXF_FLT_TX];
                rdata[SXF_FLT_RXUNF_BIT] = fault_q[SXF_FLT_RX];
            end
            SXF_OFF_WLEN:    rdata = wlen_q;
            SXF_OFF_READBACK_TEST: rdata = scr_q;
            default:         rdata = 8'h00;
        endcase
    end

    // control frame sequencer and register writes
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        csh_d  = csh_q;
        ctx_d  = ctx_q;
        addr_d = addr_q;
        rd_d   = rd_q;
        wr_en  = 1'b0;
        if (!csel) begin
            st_d  = SXF_ST_ADDR;
            cnt_d = 3'h0;
        end else if (sck_rise) begin
            csh_d = byte_in;
            cnt_d = cnt_q + 3'h1;
            case (st_q)
                SXF_ST_ADDR: if (cnt_q == SXF_BYTE_LAST) begin
                    addr_d = byte_in[7:1];
                    rd_d   = byte_in[0];
                    st_d   = SXF_ST_DATA;
                end
                SXF_ST_DATA: if (cnt_q == SXF_BYTE_LAST) begin
                    wr_en = !rd_q;
                    st_d  = SXF_ST_SKIP;
                end
                SXF_ST_SKIP: st_d = SXF_ST_SKIP;
                default:     st_d = SXF_ST_ADDR;
            endcase
        end
        if (csel && sck_rise && st_q == SXF_ST_ADDR &&
            cnt_q == SXF_BYTE_LAST) begin
            ctx_d = rdata;
        end else if (csel && sck_fall && st_q == SXF_ST_DATA && rd_q) begin
            ctx_d = {ctx_q[6:0], 1'b0};
        end
    end

    // register bank; a hardware set wins over a clear in the same cycle
    always_comb begin
        wlen_d  = wlen_q;
        scr_d   = scr_q;
        ev_clr  = wr_en && (addr_q == SXF_OFF_EVENT) &&
                  !byte_in[SXF_EV_FAULT_BIT];
        if (wr_en && addr_q == SXF_OFF_WLEN) begin
            wlen_d = byte_in;
        end
        if (wr_en && addr_q == SXF_OFF_READBACK_TEST) begin
            scr_d = byte_in;
        end
        // writes to the fault offset fall through untouched
        fault_d = ev_clr ? 2'b00 : fault_q;
        fault_d[SXF_FLT_TX] = fault_d[SXF_FLT_TX] | tx_ovf;
        fault_d[SXF_FLT_RX] = fault_d[SXF_FLT_RX] | rx_unf;
        ev_d = (ev_clr ? 1'b0 : ev_q) | tx_ovf | rx_unf;
    end

    // remote read data path and shared MISO driver
    always_comb begin
        rxp_d  = rxp_q;
        rxb_d  = rxb_q;
        hist_d = hist_q;
        miso_d = miso_q;
        oe_d   = csel || dsel;
        if (i_link_rx_valid) begin
            rxp_d = 1'b1;
            rxb_d = i_link_rx_bit;
        end
        if (csel && sck_fall && st_q == SXF_ST_DATA && rd_q) begin
            miso_d = ctx_q[7];
        end else if (dsel && !csel && sck_fall) begin
            // a missing bit is lost and shifts in as zero
            miso_d = hist_q[tap_idx];
            hist_d = {hist_q[SXF_HIST_W-2:0], rx_avail && rx_now};
            rxp_d  = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q    <= SXF_ST_ADDR;
            cnt_q   <= 3'h0;
            csh_q   <= 8'h00;
            ctx_q   <= 8'h00;
            addr_q  <= 7'h00;
            rd_q    <= 1'b0;
            wlen_q  <= SXF_WLEN_RST;
            scr_q   <= SXF_READBACK_TEST_RST;
            fault_q <= 2'b00;
            ev_q    <= 1'b0;
            rxp_q   <= 1'b0;
            rxb_q   <= 1'b0;
            hist_q  <= '0;
            miso_q  <= 1'b0;
            oe_q    <= 1'b0;
        end else if (i_ce) begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            csh_q   <= csh_d;
            ctx_q   <= ctx_d;
            addr_q  <= addr_d;
            rd_q    <= rd_d;
            wlen_q  <= wlen_d;
            scr_q   <= scr_d;
            fault_q <= fault_d;
            ev_q    <= ev_d;
            rxp_q   <= rxp_d;
            rxb_q   <= rxb_d;
            hist_q  <= hist_d;
            miso_q  <= miso_d;
            oe_q    <= oe_d;
        end
    end

    assign o_miso        = miso_q;
    assign o_miso_oe     = oe_q;
    assign o_fault_event = ev_q;

    // =====================================================================
    // checks
    sequence s_scr_wr;
        i_ce && wr_en && addr_q == SXF_OFF_READBACK_TEST;
    endsequence

    property p_tx_ovf;
        @(posedge i_clk) disable iff (i_srst)
        i_ce && tx_ovf |=> fault_q[SXF_FLT_TX] && ev_q;
    endproperty
    a_tx_ovf: assert property (p_tx_ovf)
        else $error("overflow did not set transmit fault");

    property p_rx_unf;
        @(posedge i_clk) disable iff (i_srst)
        i_ce && sck_fall && dsel && !csel && !rxp_q && !i_link_rx_valid
        |=> fault_q[SXF_FLT_RX];
    endproperty
    a_rx_unf: assert property (p_rx_unf)
        else $error("starved read did not set receive fault");

    property p_miso_delay;
        @(posedge i_clk) disable iff (i_srst)
        i_ce && dsel && !csel && sck_fall
        |=> o_miso == $past(hist_q[tap_idx]) && o_miso_oe;
    endproperty
    a_miso_delay: assert property (p_miso_delay)
        else $error("miso not taken from the delay tap");

    property p_readback_test;
        @(posedge i_clk) disable iff (i_srst)
        s_scr_wr ##1 (!wr_en)[*2] |-> scr_q == $past(byte_in, 2);
    endproperty
    a_readback_test: assert property (p_readback_test)
        else $error("readback register lost its value");

    property p_summary;
        @(posedge i_clk) disable iff (i_srst)
        fault_q != 2'b00 |-> ev_q;
    endproperty
    a_summary: assert property (p_summary)
        else $error("fault flag set without summary bit");

    property p_clear_all;
        @(posedge i_clk) disable iff (i_srst)
        $fell(ev_q) |-> fault_q == 2'b00 && $past(ev_clr);
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("summary clear left a fault flag");

    property p_no_direct;
        @(posedge i_clk) disable iff (i_srst)
        !ev_clr |=> (fault_q & $past(fault_q)) == $past(fault_q);
    endproperty
    a_no_direct: assert property (p_no_direct)
        else $error("fault flag cleared without summary clear");
endmodule
